// [aesc_control.sv]
/*
  enable, abort, recovery, soft reset and halt control of a list-based
  converter, with its control register and event interrupt.
  assumes sequencer signals share the clock and the plain register port
  never issues read and write strobes together.
*/
// Operation
// [RULE1] enable, reset, halt selects writable anytime
// [RULE2] flow fields writable only disabled or special
// [RULE3] enable powers converter; clearing aborts sequence
// [RULE4] disable discards pending and current results
// [RULE5] enable bit locks configuration fields
// [RULE6] no re-enable until disable work ends
// [RULE7] recovery interval before first triggered conversion
// [RULE8] soft reset clears flags, idles machine
// [RULE9] soft reset clears indices and list selects
// [RULE10] severe error stops converter until reset
// [RULE11] soft reset bit sticky until completion
// [RULE12] freeze select halts at next boundary
// [RULE13] wait select halts at next boundary
// [RULE14] flow mode: restart or trigger mode
// [RULE15] two-bit flow register access path select
// [RULE16] latency and recovery as parameterised counts
// [RULE17] control register readable at any time
`timescale 1ns/1ps
`default_nettype none
module aesc_control #(
  parameter int DIS_CYCLES = aesc_pkg::DIS_CYC,
  parameter int REC_CYCLES = aesc_pkg::REC_CYC
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [aesc_pkg::ADDR_W-1:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata,
  input wire logic specialModeAccess,
  input wire logic severeErr,
  input wire logic convBusy,
  input wire logic convBoundary,
  input wire logic trigger,
  input wire logic freezeMode,
  input wire logic waitMode,
  output logic analogPowerEn,
  output logic abortSeq,
  output logic discardResults,
  output logic softResetStrobe,
  output logic launchConv,
  output logic haltConv,
  output logic flowModeSelect,
  output logic abortResultStore,
  output logic [1:0] flowRegAccessCfg,
  output logic irq
);
  // ---------------------------------------------
  // parameter checks
  // ---------------------------------------------
  // counters are eight bits wide and load at least one
  if (DIS_CYCLES < 1 || DIS_CYCLES > 255 || REC_CYCLES < 1 || REC_CYCLES > 255) begin : gBad
    $error("cycle counts must lie in 1..255");
  end

  // ---------------------------------------------
  // state
  // ---------------------------------------------
  typedef struct packed {
    aesc_pkg::aesc_phase_t phase; // enable sequence phase
    aesc_pkg::aesc_ctl_t ctl;     // control register
    logic [7:0] cnt;              // phase timer
    logic severe;                 // converter inoperative
    logic [aesc_pkg::EV_W-1:0] ists; // sticky events
    logic [aesc_pkg::EV_W-1:0] ien;  // event enables
    logic power;
    logic abortP;
    logic discardP;
    logic srP;
    logic launch;
    logic halt;
    logic irq;
    logic [15:0] rdata;
  } aesc_state_t;

  aesc_state_t state_reg;
  aesc_state_t state_next;
  aesc_pkg::aesc_ctl_t wctl; // write data seen as fields
  logic ctlWr;               // write to control register
  logic haltReq;             // a low-power mode asks for a halt
  logic [aesc_pkg::EV_W-1:0] ev; // events raised this cycle

  assign wctl = aesc_pkg::aesc_ctl_t'(regWdata & aesc_pkg::CTL_WMASK);
  assign ctlWr = regWr && (regAddr == aesc_pkg::CTL_OFF);

  // ---------------------------------------------
  // next state
  // ---------------------------------------------
  always_comb begin
    state_next = state_reg;
    ev = '0;
    // one-cycle strobes fall by default
    state_next.abortP = 1'b0;
    state_next.discardP = 1'b0;
    state_next.srP = 1'b0;
    state_next.launch = 1'b0;
    // control write
    if (ctlWr) begin
      // [RULE1] anytime bits
      state_next.ctl.en = wctl.en;
      state_next.ctl.frz = wctl.frz;
      state_next.ctl.wai = wctl.wai;
      // [RULE11] sticky request bit
      if (wctl.sr) begin
        state_next.ctl.sr = 1'b1;
      end
      // [RULE2] locked flow fields
      // [RULE5] enable gates writes
      if (!state_reg.ctl.en || specialModeAccess) begin
        state_next.ctl.mode = wctl.mode;
        state_next.ctl.str = wctl.str;
        state_next.ctl.acc = wctl.acc;
      end
    end
    // enable register write
    if (regWr && regAddr == aesc_pkg::IEN_OFF) begin
      state_next.ien = regWdata[aesc_pkg::EV_W-1:0];
    end
    // severe error latches; converter stays dead
    if (severeErr && !state_reg.severe) begin
      ev[aesc_pkg::EV_SEVERE] = 1'b1;
    end
    // enable sequence
    case (state_reg.phase)
      aesc_pkg::PH_OFF: begin
        // [RULE16] recovery count loads
        if (state_reg.ctl.en && !state_reg.ctl.sr) begin
          state_next.phase = aesc_pkg::PH_RECOVER;
          state_next.cnt = 8'(REC_CYCLES);
        end
      end
      aesc_pkg::PH_RECOVER, aesc_pkg::PH_READY: begin
        if (!state_reg.ctl.en) begin
          // [RULE3] abort on disable
          // [RULE4] discard results
          state_next.phase = aesc_pkg::PH_DISABLING;
          state_next.cnt = 8'(DIS_CYCLES);
          state_next.abortP = 1'b1;
          state_next.discardP = 1'b1;
        end else if (state_reg.phase == aesc_pkg::PH_RECOVER) begin
          // [RULE7] hold launch until recovered
          if (state_reg.cnt == 8'h01) begin
            state_next.phase = aesc_pkg::PH_READY;
            ev[aesc_pkg::EV_READY] = 1'b1;
          end else begin
            state_next.cnt = state_reg.cnt - 8'h01;
          end
        end
      end
      aesc_pkg::PH_DISABLING: begin
        // [RULE6] stay off until work ends
        // bounded even if the sequencer never drops busy
        if (!convBusy || state_reg.cnt == 8'h01) begin
          state_next.phase = aesc_pkg::PH_OFF;
          ev[aesc_pkg::EV_DISDONE] = 1'b1;
        end else begin
          state_next.cnt = state_reg.cnt - 8'h01;
        end
      end
      aesc_pkg::PH_SRESET: begin
        // [RULE11] hardware clears on completion
        if (state_reg.cnt == 8'h01) begin
          state_next.phase = aesc_pkg::PH_OFF;
          // a request written in the finishing cycle wins over the clear
          state_next.ctl.sr = ctlWr && wctl.sr;
          state_next.severe = 1'b0;
          ev[aesc_pkg::EV_SRDONE] = 1'b1;
        end else begin
          state_next.cnt = state_reg.cnt - 8'h01;
        end
      end
      default: begin
        state_next.phase = aesc_pkg::PH_OFF;
      end
    endcase
    // [RULE8] soft reset idles the enable sequence
    // [RULE9] strobe clears indices, list selects
    if (state_reg.ctl.sr && state_reg.phase != aesc_pkg::PH_SRESET) begin
      state_next.phase = aesc_pkg::PH_SRESET;
      state_next.cnt = 8'(aesc_pkg::SRST_CYC);
      state_next.srP = 1'b1;
    end
    // a new severe error beats the clear at reset end
    if (severeErr) begin
      state_next.severe = 1'b1;
    end
    // [RULE3] power follows enabled phases
    state_next.power = (state_next.phase == aesc_pkg::PH_RECOVER) || (state_next.phase == aesc_pkg::PH_READY);
    // [RULE12] freeze halt select
    // [RULE13] wait halt select
    if (!haltReq) begin
      state_next.halt = 1'b0;
    end else if (convBoundary || !convBusy) begin
      state_next.halt = 1'b1;
    end
    // [RULE10] no launch while inoperative
    // [RULE7] only once recovered
    state_next.launch = trigger && state_reg.phase == aesc_pkg::PH_READY && state_reg.ctl.en
                        && !state_reg.severe && !state_reg.halt && !state_reg.ctl.sr;
    // status: set wins over a clear in the same cycle
    if (regWr && regAddr == aesc_pkg::ICLR_OFF) begin
      state_next.ists = state_reg.ists & ~regWdata[aesc_pkg::EV_W-1:0];
    end
    state_next.ists = state_next.ists | ev;
    state_next.irq = |(state_next.ists & state_next.ien);
    // [RULE17] read data, one cycle only
    state_next.rdata = 16'h0000;
    if (regRd) begin
      case (regAddr)
        aesc_pkg::CTL_OFF: state_next.rdata = state_reg.ctl;
        aesc_pkg::ISTS_OFF: state_next.rdata = 16'(state_reg.ists);
        aesc_pkg::IEN_OFF: state_next.rdata = 16'(state_reg.ien);
        aesc_pkg::STAT_OFF: state_next.rdata = {11'h000, state_reg.halt, state_reg.severe,
                                                state_reg.phase};
        default: state_next.rdata = 16'h0000;
      endcase
    end
  end

  // halt wanted by a low-power mode whose select is set
  assign haltReq = (freezeMode && state_reg.ctl.frz) || (waitMode && state_reg.ctl.wai);

  // ---------------------------------------------
  // state register
  // ---------------------------------------------
  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_reg <= '0;
      state_reg.phase <= aesc_pkg::PH_OFF;
      state_reg.ctl <= aesc_pkg::aesc_ctl_t'(aesc_pkg::CTL_RST);
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------
  // outputs, all from flops
  // ---------------------------------------------
  assign regRdata = state_reg.rdata;
  assign analogPowerEn = state_reg.power;
  assign abortSeq = state_reg.abortP;
  assign discardResults = state_reg.discardP;
  assign softResetStrobe = state_reg.srP;
  assign launchConv = state_reg.launch;
  assign haltConv = state_reg.halt;
  // [RULE14] 0 restart, 1 trigger mode
  assign flowModeSelect = state_reg.ctl.mode;
  assign abortResultStore = state_reg.ctl.str;
  // [RULE15] none, internal, bus, both
  assign flowRegAccessCfg = state_reg.ctl.acc;
  assign irq = state_reg.irq;

  // ---------------------------------------------
  // assertions
  // ---------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  logic phReady;
  logic phRec;
  logic phDis;
  assign phReady = state_reg.phase == aesc_pkg::PH_READY;
  assign phRec = state_reg.phase == aesc_pkg::PH_RECOVER;
  assign phDis = state_reg.phase == aesc_pkg::PH_DISABLING;

  a_anytime_bits: assert property (ctlWr |=> state_reg.ctl.frz == $past(regWdata[13])) // [RULE1]
    else $error("freeze select write lost");
  a_locked_fields: assert property ( // [RULE2]
    ctlWr && state_reg.ctl.en && !specialModeAccess
    |=> $stable(flowRegAccessCfg) && $stable(flowModeSelect))
    else $error("locked field changed");
  a_abort_discard: assert property ( // [RULE3]
    (phReady || phRec) && !state_reg.ctl.en && !state_reg.ctl.sr
    |=> abortSeq && discardResults ##1 !abortSeq)
    else $error("disable without abort strobe");
  a_refuse_enable: assert property (phDis |=> !analogPowerEn) // [RULE6]
    else $error("powered while disabling");
  a_dis_bound: assert property (phDis && state_reg.cnt == 8'h01 |=> !phDis) // [RULE16]
    else $error("disable latency overran");
  a_recover_gate: assert property ( // [RULE7]
    phRec && state_reg.cnt > 8'h01 && state_reg.ctl.en
    && !state_reg.ctl.sr |=> !phReady ##1 !launchConv)
    else $error("launch before recovery");
  a_sr_strobe: assert property ( // [RULE8]
    state_reg.ctl.sr && !$past(state_reg.ctl.sr)
    |=> softResetStrobe ##1 !softResetStrobe)
    else $error("soft reset strobe wrong");
  a_sr_sticky: assert property ( // [RULE11]
    state_reg.ctl.sr && !(state_reg.phase == aesc_pkg::PH_SRESET
    && state_reg.cnt == 8'h01) |=> state_reg.ctl.sr)
    else $error("soft reset bit cleared early");
  a_severe_stop: assert property (state_reg.severe |=> !launchConv) // [RULE10]
    else $error("launch while inoperative");
  a_halt_release: assert property (!haltReq |=> !haltConv) // [RULE12]
    else $error("halt held without request");
  a_read_back: assert property ( // [RULE17]
    regRd && regAddr == aesc_pkg::CTL_OFF
    |=> regRdata == $past(state_reg.ctl))
    else $error("control read mismatch");

  c_enable_ready: cover property (phRec ##[1:300] phReady ##[1:20] launchConv);
  c_disable_busy: cover property (phDis && convBusy ##1 phDis);
  c_soft_reset: cover property (state_reg.severe ##[1:20] softResetStrobe);
  c_halt: cover property (haltReq ##[1:20] haltConv);
endmodule
`default_nettype wire

// [aesc_pkg.sv]
/*
  shared constants and types of the converter enable and soft reset control.
  assumes a single 25 MHz clock and a word-indexed plain register port.
*/
package aesc_pkg;
  // ---------------------------------------------
  // register offsets
  // ---------------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [4:0] CTL_OFF = 5'h00;  // converter_control_zero
  localparam logic [4:0] ISTS_OFF = 5'h04; // sticky event status, read only
  localparam logic [4:0] ICLR_OFF = 5'h08; // write one to clear, reads zero
  localparam logic [4:0] IEN_OFF = 5'h0C;  // interrupt enable
  localparam logic [4:0] STAT_OFF = 5'h10; // live block state
  // ---------------------------------------------
  // control fields and reset value
  // ---------------------------------------------
  localparam logic [15:0] CTL_RST = 16'h0000;
  localparam logic [15:0] CTL_WMASK = 16'hFF00; // reserved low byte
  localparam logic [1:0] ACC_NONE = 2'h0;  // no path to flow register
  localparam logic [1:0] ACC_INT = 2'h1;   // internal interface only
  localparam logic [1:0] ACC_BUS = 2'h2;   // data bus only
  localparam logic [1:0] ACC_BOTH = 2'h3;  // both paths
  typedef struct packed {
    logic en;         // 15 converter enable
    logic sr;         // 14 soft_reset_request
    logic frz;        // 13 freeze_halt_select
    logic wai;        // 12 wait_halt_select
    logic [1:0] acc;  // 11:10 flow_reg_access_cfg
    logic str;        // 9 abort_result_store
    logic mode;       // 8 flow_mode_select
    logic [7:0] rsvd; // reads zero
  } aesc_ctl_t;
  // ---------------------------------------------
  // events and timing
  // ---------------------------------------------
  localparam int EV_W = 4;
  localparam int EV_SEVERE = 0;
  localparam int EV_SRDONE = 1;
  localparam int EV_READY = 2;
  localparam int EV_DISDONE = 3;
  localparam int CLK_NS = 40;
  localparam int T_DISABLE_NS = 1000; // longest disable latency
  localparam int T_REC_NS = 400;      // least recovery after enable
  localparam int DIS_CYC = T_DISABLE_NS / CLK_NS;
  localparam int REC_CYC = (T_REC_NS + CLK_NS - 1) / CLK_NS;
  localparam int SRST_CYC = 2;
  typedef enum logic [2:0] {PH_OFF, PH_DISABLING, PH_RECOVER, PH_READY, PH_SRESET} aesc_phase_t;
endpackage

// [aesc_control_bench.sv]
/*
  self-checking bench of the converter enable and soft reset control.
  assumes the design package is compiled first; the bench drives every input port.
*/
`timescale 1ns/1ps
`default_nettype none
module aesc_control_bench;
  // ---------------------------------------------
  // signals and short counts
  // ---------------------------------------------
  localparam int DIS_N = 5; // short disable bound keeps the run brief
  localparam int REC_N = 3; // short recovery interval
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [aesc_pkg::ADDR_W-1:0] regAddr = 5'h00;
  logic [15:0] regWdata = 16'h0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [15:0] regRdata;
  logic specialModeAccess = 1'b0;
  logic severeErr = 1'b0;
  logic convBusy = 1'b0;
  logic convBoundary = 1'b0;
  logic trigger = 1'b0;
  logic freezeMode = 1'b0;
  logic waitMode = 1'b0;
  logic analogPowerEn, abortSeq, discardResults, softResetStrobe, launchConv, haltConv;
  logic flowModeSelect, abortResultStore, irq;
  logic [1:0] flowRegAccessCfg;
  int fail_count = 0;
  int samples_checked = 0;
  int nLaunch = 0, nAbort = 0, nDiscard = 0, nStrobe = 0; // pulse tallies
  int n0, n1;
  logic [15:0] d, v;
  always #20 clock = ~clock;
  aesc_control #(.DIS_CYCLES(DIS_N), .REC_CYCLES(REC_N)) aesc_control_i (
    .clock(clock), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .specialModeAccess(specialModeAccess),
    .severeErr(severeErr), .convBusy(convBusy), .convBoundary(convBoundary), .trigger(trigger),
    .freezeMode(freezeMode), .waitMode(waitMode), .analogPowerEn(analogPowerEn),
    .abortSeq(abortSeq), .discardResults(discardResults), .softResetStrobe(softResetStrobe),
    .launchConv(launchConv), .haltConv(haltConv), .flowModeSelect(flowModeSelect),
    .abortResultStore(abortResultStore), .flowRegAccessCfg(flowRegAccessCfg), .irq(irq));
  // tally single-cycle pulses so scenarios compare deltas, not moments
  always @(posedge clock) begin
    if (launchConv === 1'b1) nLaunch++;
    if (abortSeq === 1'b1) nAbort++;
    if (discardResults === 1'b1) nDiscard++;
    if (softResetStrobe === 1'b1) nStrobe++;
  end
  // ---------------------------------------------
  // access and compare tasks
  // ---------------------------------------------
  task automatic end_sim();
    $display("compares %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [4:0] a, input logic [15:0] wd);
    @(posedge clock);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= wd;
    @(posedge clock);
    regWr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [4:0] a, output logic [15:0] rdv);
    @(posedge clock);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRd <= 1'b0;
    #1;
    rdv = regRdata;
  endtask
  task automatic rdChk(input string what, input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] r;
    rd(a, r);
    chk(what, r, exp);
  endtask
  task automatic trig();
    @(posedge clock);
    trigger <= 1'b1;
    @(posedge clock);
    trigger <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
  endtask
  // bounded wait for power; a hang goes straight to the report
  task automatic waitPower();
    for (int i = 0; i < 20; i++) begin
      if (analogPowerEn === 1'b1) break;
      @(posedge clock);
      #1;
    end
    chk("power", {15'h0000, analogPowerEn}, 16'h0001);
    if (analogPowerEn !== 1'b1) end_sim();
  endtask
  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    rdChk("control reset", aesc_pkg::CTL_OFF, aesc_pkg::CTL_RST);
    rdChk("unmapped", 5'h14, 16'h0000);
    chk("power off", {15'h0000, analogPowerEn}, 16'h0000);
    // flow fields every code while disabled, reserved byte reads zero
    for (int i = 0; i < 4; i++) begin
      d = {4'h0, i[1:0], i[0], i[1], 8'h00};
      wr(aesc_pkg::CTL_OFF, d | 16'h00FF);
      rdChk("control flow", aesc_pkg::CTL_OFF, d);
      chk("access cfg", {14'h0000, flowRegAccessCfg}, {14'h0000, i[1:0]});
      chk("mode store", {14'h0000, flowModeSelect, abortResultStore}, {14'h0000, i[1], i[0]});
    end
    wr(aesc_pkg::ICLR_OFF, 16'h000F);
    // enable, trigger inside recovery is dropped
    wr(aesc_pkg::CTL_OFF, 16'h8500);
    n0 = nLaunch;
    trig();
    chk("early launch", 16'(nLaunch - n0), 16'h0000);
    repeat (REC_N + 2) @(posedge clock);
    trig();
    chk("ready launch", 16'(nLaunch - n0), 16'h0001);
    chk("power on", {15'h0000, analogPowerEn}, 16'h0001);
    rdChk("ready status", aesc_pkg::ISTS_OFF, 16'h0004);
    // lock while enabled, unlocked by special access
    wr(aesc_pkg::CTL_OFF, 16'h8A00);
    rdChk("locked", aesc_pkg::CTL_OFF, 16'h8500);
    @(posedge clock);
    specialModeAccess <= 1'b1;
    wr(aesc_pkg::CTL_OFF, 16'h8A00);
    @(posedge clock);
    specialModeAccess <= 1'b0;
    rdChk("special write", aesc_pkg::CTL_OFF, 16'h8A00);
    // freeze then wait halt, selected and unselected
    for (int k = 0; k < 2; k++) begin
      d = (k == 0) ? 16'hAA00 : 16'h9A00;
      wr(aesc_pkg::CTL_OFF, d);
      rdChk("halt select", aesc_pkg::CTL_OFF, d);
      @(posedge clock);
      freezeMode <= (k == 0);
      waitMode <= (k == 1);
      repeat (3) @(posedge clock);
      #1;
      chk("halt on", {15'h0000, haltConv}, 16'h0001);
      wr(aesc_pkg::CTL_OFF, 16'h8A00);
      repeat (3) @(posedge clock);
      #1;
      chk("halt off", {15'h0000, haltConv}, 16'h0000);
      @(posedge clock);
      freezeMode <= 1'b0;
      waitMode <= 1'b0;
    end
    // disable while busy, re-enable refused until work ends
    wr(aesc_pkg::IEN_OFF, 16'h0008);
    wr(aesc_pkg::ICLR_OFF, 16'h000F);
    @(posedge clock);
    convBusy <= 1'b1;
    n0 = nAbort;
    n1 = nDiscard;
    wr(aesc_pkg::CTL_OFF, 16'h0A00);
    wr(aesc_pkg::CTL_OFF, 16'h8A00);
    repeat (2) @(posedge clock);
    #1;
    chk("reenable held", {15'h0000, analogPowerEn}, 16'h0000);
    chk("abort pulse", 16'(nAbort - n0), 16'h0001);
    chk("discard pulse", 16'(nDiscard - n1), 16'h0001);
    @(posedge clock);
    convBusy <= 1'b0;
    waitPower();
    chk("irq raised", {15'h0000, irq}, 16'h0001);
    rd(aesc_pkg::ISTS_OFF, v);
    chk("disable done", v & 16'h0008, 16'h0008);
    wr(aesc_pkg::ICLR_OFF, 16'h0008);
    repeat (2) @(posedge clock);
    #1;
    chk("irq cleared", {15'h0000, irq}, 16'h0000);
    rdChk("clear reads zero", aesc_pkg::ICLR_OFF, 16'h0000);
    // severe error stops launches until soft reset
    repeat (REC_N + 2) @(posedge clock);
    severeErr <= 1'b1;
    @(posedge clock);
    severeErr <= 1'b0;
    n0 = nLaunch;
    trig();
    chk("severe launch", 16'(nLaunch - n0), 16'h0000);
    rd(aesc_pkg::STAT_OFF, v);
    chk("severe flag", v & 16'h0008, 16'h0008);
    n1 = nStrobe;
    // soft reset then an attempted clear right behind it
    @(posedge clock);
    regWr <= 1'b1;
    regAddr <= aesc_pkg::CTL_OFF;
    regWdata <= 16'hCA00;
    @(posedge clock);
    regWdata <= 16'h8A00;
    @(posedge clock);
    regWr <= 1'b0;
    regRd <= 1'b1;
    @(posedge clock);
    regRd <= 1'b0;
    #1;
    chk("reset sticky", regRdata, 16'hCA00);
    repeat (4) @(posedge clock);
    rdChk("reset self clear", aesc_pkg::CTL_OFF, 16'h8A00);
    chk("reset strobe", 16'(nStrobe - n1), 16'h0001);
    rd(aesc_pkg::STAT_OFF, v);
    chk("severe cleared", v & 16'h0008, 16'h0000);
    waitPower();
    repeat (REC_N + 2) @(posedge clock);
    trig();
    chk("launch again", 16'(nLaunch - n0), 16'h0001);
    end_sim();
  end
endmodule
`default_nettype wire
